/* test/spfc_cpu_model.sv */
// ------------------------------------------------------------
// Processor core model issuing program store and load pulses
// ------------------------------------------------------------
module spfc_cpu_model (
  input wire logic clk_in,
  input wire logic halt_in,
  output logic store_out,
  output logic load_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic active = 1'b0;

  initial begin
    store_out = 1'b0;
    load_out = 1'b0;
  end

  // Issues one pulse after gap cycles; a second overlapping request is dropped.
  task automatic issue(input logic is_load, input int gap);
    int k;
    k = 0;
    if (active) return;
    active = 1'b1;
    repeat (gap) @(posedge clk_in);
    // A halted core fetches nothing, so it waits for the halt to end.
    while (halt_in === 1'b1 && k < 500) begin
      @(posedge clk_in);
      k++;
    end
    if (is_load) load_out <= 1'b1;
    else store_out <= 1'b1;
    @(posedge clk_in);
    store_out <= 1'b0;
    load_out <= 1'b0;
    active = 1'b0;
  endtask
endmodule

/* test/spfc_top_test.sv */
module spfc_top_test
  import spfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int OPC = 20;
  localparam logic [16:0] BOOTV = 17'h1f000;
  logic clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, r0 = 8'h00, r1 = 8'h00, rdata, ld_data;
  logic [15:0] ptr = 16'h0000;
  logic gie = 1'b0, eeb = 1'b0, fuse = 1'b1;
  logic [7:0] fl = 8'ha6, sig = 8'h5a;
  logic store, load, ld_v, irq, blk, halt, er, wrp;
  logic [16:0] vec, page;
  logic [3:0] lock;
  int err_count = 0, check_count = 0, erase_n = 0, write_n = 0;

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  // Flash pulses are counted so that missing or extra ones show.
  always @(posedge clk) begin
    if (er === 1'b1) erase_n++;
    if (wrp === 1'b1) write_n++;
  end

  spfc_top #(.BOOT_VECTOR(BOOTV), .OP_CYCLES(OPC)) spfc_top_i (
    .clk_sys_in(clk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .store_in(store), .load_in(load),
    .pointer_in(ptr), .r0_in(r0), .r1_in(r1), .global_ie_in(gie),
    .eeprom_busy_in(eeb), .boot_reset_fuse_in(fuse), .fuse_low_in(fl),
    .signature_in(sig), .load_data_out(ld_data), .load_valid_out(ld_v),
    .ready_irq_out(irq), .rww_blocked_out(blk), .cpu_halt_out(halt),
    .reset_vector_out(vec), .flash_erase_out(er), .flash_write_out(wrp),
    .flash_page_addr_out(page), .boot_lock_out(lock));

  spfc_cpu_model spfc_cpu_model_i (
    .clk_in(clk), .halt_in(halt), .store_out(store), .load_out(load));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [16:0] a, e, input string m);
    check_count++;
    if (a !== e) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Polls the register until the enable bit drops, within a bound.
  task automatic wait_idle();
    logic [7:0] d;
    d = 8'h01;
    for (int i = 0; i < 100 && d[0] !== 1'b0; i++) rd(SPFC_ADDR_CSR, d);
    chk(17'(d[0]), 17'h0, "operation never finished");
  endtask

  task automatic csr_is(input logic [7:0] e, input string m);
    logic [7:0] d;
    rd(SPFC_ADDR_CSR, d);
    chk(17'(d), 17'(e), m);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    csr_is(SPFC_CSR_RESET, "csr reset");
    chk(17'(lock), 17'hf, "lock reset");
    chk(vec, 17'h0, "app vector");
    fuse <= 1'b0;
    wr(SPFC_ADDR_CSR, 8'hff);
    cyc(4);
    @(negedge clk);
    chk(vec, BOOTV, "boot vector");
    chk(vec, BOOTV, "software kept fuse");
    @(posedge clk);
    csr_is(8'h80, "illegal all ones");
    fuse <= 1'b1;
    cyc(4);
    @(negedge clk);
    chk(vec, 17'h0, "app vector again");
    @(posedge clk);
  endtask

  task automatic t_erase();
    int n;
    logic [7:0] d;
    n = erase_n;
    ptr <= 16'h1234;
    gie <= 1'b1;
    wr(SPFC_ADDR_CSR, 8'h83);
    spfc_cpu_model_i.issue(1'b0, 0);
    ptr <= 16'h5555;
    cyc(1);
    @(negedge clk);
    chk(17'(erase_n - n), 17'h1, "erase pulse");
    chk(17'(blk), 17'h1, "busy set");
    chk(17'(halt), 17'h0, "no halt rww");
    chk(page, 17'h00900, "page latched");
    chk(17'(irq), 17'h0, "irq gated");
    @(posedge clk);
    rd(SPFC_ADDR_CSR, d);
    chk(17'({d[6], d[0]}), 17'h3, "busy and enable");
    wr(SPFC_ADDR_CSR, 8'h91);
    spfc_cpu_model_i.issue(1'b0, 0);
    @(negedge clk);
    chk(17'(blk), 17'h1, "reenable refused");
    @(posedge clk);
    wait_idle();
    cyc(2);
    @(negedge clk);
    chk(17'(irq), 17'h1, "ready irq");
    chk(17'(blk), 17'h1, "busy held");
    @(posedge clk);
    gie <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(17'(irq), 17'h0, "irq global off");
    @(posedge clk);
    r0 <= 8'h34;
    r1 <= 8'h12;
    wr(SPFC_ADDR_CSR, 8'h81);
    spfc_cpu_model_i.issue(1'b0, 0);
    cyc(2);
    @(negedge clk);
    chk(17'(blk), 17'h0, "fill clears busy");
    @(posedge clk);
    csr_is(8'h80, "fill done");
  endtask

  task automatic t_write_no_read_while_write_section();
    int n;
    n = write_n;
    ptr <= 16'hc000;
    wr(SPFC_ADDR_EXT, 8'h03);
    cyc(1);
    // Erase and write address the same page.
    wr(SPFC_ADDR_CSR, 8'h03);
    spfc_cpu_model_i.issue(1'b0, 0);
    wait_idle();
    wr(SPFC_ADDR_CSR, 8'h05);
    spfc_cpu_model_i.issue(1'b0, 0);
    cyc(1);
    @(negedge clk);
    chk(17'(write_n - n), 17'h1, "write pulse");
    chk(17'(halt), 17'h1, "halt no_read_while_write_section");
    chk(page, 17'h1e000, "extended page");
    @(posedge clk);
    wait_idle();
    chk(17'(halt), 17'h0, "halt released");
    csr_is(8'h00, "write flag cleared");
    wr(SPFC_ADDR_CSR, 8'h11);
    spfc_cpu_model_i.issue(1'b0, 0);
    cyc(2);
    wr(SPFC_ADDR_EXT, 8'h00);
  endtask

  // Arms erase, write and lock set and lets the store arrive too late.
  task automatic t_timeout();
    logic [7:0] c[3] = '{8'h03, 8'h05, 8'h09};
    int n;
    foreach (c[i]) begin
      n = erase_n + write_n;
      wr(SPFC_ADDR_CSR, c[i]);
      spfc_cpu_model_i.issue(1'b0, 5);
      cyc(2);
      chk(17'(erase_n + write_n - n), 17'h0, "late store");
      csr_is(8'h00, "timeout clear");
      chk(17'(lock), 17'hf, "lock untouched");
    end
  endtask

  task automatic t_illegal();
    logic [7:0] c[5] = '{8'h07, 8'h0f, 8'h13, 8'h02, 8'h1b};
    int n;
    foreach (c[i]) begin
      n = erase_n + write_n;
      wr(SPFC_ADDR_CSR, c[i]);
      spfc_cpu_model_i.issue(1'b0, 0);
      cyc(2);
      chk(17'(erase_n + write_n - n), 17'h0, "illegal code");
      csr_is(8'h00, "illegal ignored");
    end
  endtask

  task automatic t_lock_sig();
    r0 <= 8'hd7;
    wr(SPFC_ADDR_CSR, 8'h09);
    spfc_cpu_model_i.issue(1'b0, 3);
    cyc(2);
    @(negedge clk);
    chk(17'(lock), 17'h5, "lock programmed");
    @(posedge clk);
    ptr <= 16'h0001;
    wr(SPFC_ADDR_CSR, 8'h09);
    spfc_cpu_model_i.issue(1'b1, 1);
    @(negedge clk);
    chk(17'({ld_v, ld_data[5:2]}), 17'h15, "lock read");
    @(posedge clk);
    cyc(5);
    ptr <= 16'h0000;
    wr(SPFC_ADDR_CSR, 8'h09);
    spfc_cpu_model_i.issue(1'b1, 0);
    @(negedge clk);
    chk(17'(ld_data), 17'(fl), "fuse read");
    @(posedge clk);
    cyc(5);
    wr(SPFC_ADDR_CSR, 8'h21);
    spfc_cpu_model_i.issue(1'b1, 2);
    @(negedge clk);
    chk(17'({ld_v, ld_data}), 17'({1'b1, sig}), "signature");
    @(posedge clk);
    cyc(5);
  endtask

  task automatic t_eeprom();
    int n;
    n = erase_n;
    eeb <= 1'b1;
    cyc(3);
    wr(SPFC_ADDR_CSR, 8'h03);
    spfc_cpu_model_i.issue(1'b0, 0);
    cyc(2);
    chk(17'(erase_n - n), 17'h0, "eeprom blocks");
    csr_is(8'h00, "eeprom csr");
    eeb <= 1'b0;
    cyc(3);
  endtask

  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The watchdog ends a hung run as a failure.
  initial begin
    #(50 * 20000);
    err_count++;
    summarize();
  end

  // Reset is held six cycles, then the scenarios run in turn.
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(3);
    t_reset();
    t_erase();
    t_write_no_read_while_write_section();
    t_timeout();
    t_illegal();
    t_lock_sig();
    t_eeprom();
    summarize();
  end
endmodule

/* verilog/spfc_buf_mem.sv */
// Temporary page buffer: one word per location, registered read data.
module spfc_buf_mem
  import spfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [SPFC_WORD_BITS-1:0] waddr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [SPFC_WORD_BITS-1:0] raddr_in,
  output logic [15:0] rdata_out
);

  logic [15:0] mem [SPFC_BUF_WORDS];

  // Write port and registered read port.
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule

/* verilog/spfc_pkg.sv */
package spfc_pkg;

  // ----------------------------------------------------------------------
  // Control and status register bit positions
  // ----------------------------------------------------------------------
  localparam int SPFC_BIT_IE = 7;
  localparam int SPFC_BIT_BUSY = 6;
  localparam int SPFC_BIT_SIG = 5;
  localparam int SPFC_BIT_REEN = 4;
  localparam int SPFC_BIT_LOCK = 3;
  localparam int SPFC_BIT_PGWR = 2;
  localparam int SPFC_BIT_PGER = 1;
  localparam int SPFC_BIT_EN = 0;
  localparam logic [7:0] SPFC_CSR_RESET = 8'h00;

  // Register offsets on the local register port.
  localparam logic [3:0] SPFC_ADDR_CSR = 4'h0;
  localparam logic [3:0] SPFC_ADDR_EXT = 4'h1;

  // Low five bit command codes; all but SPFC_CMD_REEN are legal.
  localparam logic [4:0] SPFC_CMD_SIG = 5'h11;
  localparam logic [4:0] SPFC_CMD_LOCK = 5'h09;
  localparam logic [4:0] SPFC_CMD_PGWR = 5'h05;
  localparam logic [4:0] SPFC_CMD_PGER = 5'h03;
  localparam logic [4:0] SPFC_CMD_FILL = 5'h01;
  localparam logic [4:0] SPFC_CMD_REEN = 5'h11 ^ 5'h01 ^ 5'h10 ^ 5'h10;

  // Arming windows in clock cycles.
  localparam logic [2:0] SPFC_STORE_WIN = 3'h4;
  localparam logic [2:0] SPFC_LOAD_WIN = 3'h3;

  // Page geometry: word-in-page bits and buffer size.
  localparam int SPFC_WORD_BITS = 7;
  localparam int SPFC_BUF_WORDS = 128;

  // Reset vector when the boot reset fuse is unprogrammed.
  localparam logic [16:0] SPFC_APP_VECTOR = 17'h00000;

  // Default flash operation time in cycles.
  localparam int SPFC_OP_CYCLES = 100;

  typedef enum logic [2:0] {
    SPFC_IDLE,
    SPFC_ARMED,
    SPFC_BUSY
  } spfc_state_e;

endpackage

/* verilog/spfc_top.sv */
// Contract
// - Boot fuse selects application or boot vector.
// - Software cannot alter fuse values.
// - Ready interrupt while enabled, global, idle.
// - Erase/write of an RWW page sets busy, blocks section.
// - Busy cleared by re-enable or fill.
// - Re-enable armed four cycles; refused busy.
// - Re-enable during fill discards buffer.
// - Signature read by load, store ignored.
// - Lock set programs lock bits from R0.
// - Lock flag clears on done or timeout.
// - Load after lock arm returns lock/fuse.
// - Page write stores buffer to page; code only pulses the write, buffer data not output.
// - Write flag clears; halt for NO_READ_WHILE_WRITE_SECTION page.
// - Erase page; clear flag; halt NO_READ_WHILE_WRITE_SECTION.
// - Fill stores R1:R0 at pointer word.
// - Store enable lasts four cycles, auto-clears.
// - Store enable held during erase/write.
// - Only five command codes take effect.
// - Pointer is extended, high, low bytes.
// - Address latched when operation starts.
// - Loads address flash by byte via Z0.
// - Buffer cleared after write, re-enable, reset.
// - EEPROM write blocks programming and reads.
// - Zero R0 bits 5..2 program lock bits.
//
// The implementer's own choices: the address map and strobed register access.
module spfc_top
  import spfc_pkg::*;
#(
  parameter logic [16:0] BOOT_VECTOR = 17'h1f000,
  parameter logic [16:0] NO_READ_WHILE_WRITE_SECTION_START = 17'h1e000,
  parameter int OP_CYCLES = SPFC_OP_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic store_in,
  input wire logic load_in,
  input wire logic [15:0] pointer_in,
  input wire logic [7:0] r0_in,
  input wire logic [7:0] r1_in,
  input wire logic global_ie_in,
  input wire logic eeprom_busy_in,
  input wire logic boot_reset_fuse_in,
  input wire logic [7:0] fuse_low_in,
  input wire logic [7:0] signature_in,
  output logic [7:0] load_data_out,
  output logic load_valid_out,
  output logic ready_irq_out,
  output logic rww_blocked_out,
  output logic cpu_halt_out,
  output logic [16:0] reset_vector_out,
  output logic flash_erase_out,
  output logic flash_write_out,
  output logic [16:0] flash_page_addr_out,
  output logic [3:0] boot_lock_out
);

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] ee_sync;
  logic [1:0] fuse_sync;

  // EEPROM busy and the fuse level come from outside this clock.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ee_sync <= 2'h0;
      fuse_sync <= 2'h3;
    end else begin
      ee_sync <= {ee_sync[0], eeprom_busy_in};
      fuse_sync <= {fuse_sync[0], boot_reset_fuse_in};
    end
  end

  // ----------------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------------
  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == SPFC_CMD_SIG) || (c == SPFC_CMD_LOCK) ||
                (c == SPFC_CMD_PGWR) || (c == SPFC_CMD_PGER) ||
                (c == SPFC_CMD_FILL);
  endfunction

  spfc_state_e state;
  spfc_state_e next_state;
  logic ie;
  logic next_ie;
  logic busy;
  logic next_busy;
  logic [4:0] cmd;
  logic [4:0] next_cmd;
  logic reen;
  logic next_reen;
  logic [2:0] win;
  logic [2:0] next_win;
  logic [15:0] op_cnt;
  logic [15:0] next_op_cnt;
  logic [16:0] page;
  logic [16:0] next_page;
  logic [7:0] ext;
  logic [7:0] next_ext;
  logic [3:0] lock;
  logic [3:0] next_lock;
  logic [SPFC_BUF_WORDS-1:0] filled;
  logic [SPFC_BUF_WORDS-1:0] next_filled;
  logic halt;
  logic next_halt;
  logic do_erase;
  logic do_write;
  logic buf_we;
  logic [23:0] zptr;
  logic [16:0] word_addr;
  logic [SPFC_WORD_BITS-1:0] widx;
  logic wr_csr;
  logic [4:0] wr_cmd;
  logic [15:0] buf_rdata;

  // Full pointer: extended, high and low bytes.
  assign zptr = {ext, pointer_in};
  assign word_addr = zptr[17:1];
  assign widx = word_addr[SPFC_WORD_BITS-1:0];
  assign wr_csr = reg_wr_in && (reg_addr_in == SPFC_ADDR_CSR);
  assign wr_cmd = reg_wdata_in[4:0];

  // Next-state logic for the command sequencer.
  always_comb begin
    next_state = state;
    next_ie = ie;
    next_busy = busy;
    next_cmd = cmd;
    next_reen = reen;
    next_win = win;
    next_op_cnt = op_cnt;
    next_page = page;
    next_ext = ext;
    next_lock = lock;
    next_filled = filled;
    next_halt = halt;
    do_erase = 1'b0;
    do_write = 1'b0;
    buf_we = 1'b0;
    if (reg_wr_in && (reg_addr_in == SPFC_ADDR_EXT)) begin
      next_ext = reg_wdata_in;
    end
    if (wr_csr) begin
      next_ie = reg_wdata_in[SPFC_BIT_IE];
    end
    case (state)
      SPFC_IDLE: begin
        // Arm only on a legal code and no EEPROM write.
        if (wr_csr && !ee_sync[1]) begin
          if (legal_cmd(wr_cmd) && wr_cmd != 5'h11) begin
            next_state = SPFC_ARMED;
            // The signature bit rides on the plain enable code.
            next_cmd = (wr_cmd == SPFC_CMD_FILL &&
                        reg_wdata_in[SPFC_BIT_SIG]) ? SPFC_CMD_SIG : wr_cmd;
            next_reen = 1'b0;
            next_win = SPFC_STORE_WIN;
          end
          if (wr_cmd == 5'h11) begin
            // Writing the re-enable clears the buffer and arms a store.
            next_filled = '0;
            next_state = SPFC_ARMED;
            next_cmd = 5'h11;
            next_reen = 1'b1;
            next_win = SPFC_STORE_WIN;
          end
        end
      end
      SPFC_ARMED: begin
        next_win = win - 3'h1;
        if (store_in) begin
          next_state = SPFC_IDLE;
          if (reen) begin
            next_busy = 1'b0;
          end else if (cmd == SPFC_CMD_LOCK) begin
            next_lock = lock & r0_in[5:2];
          end else if (cmd == SPFC_CMD_FILL) begin
            next_busy = 1'b0;
            if (!filled[widx]) begin
              buf_we = 1'b1;
              next_filled[widx] = 1'b1;
            end
          end else if (cmd == SPFC_CMD_PGER || cmd == SPFC_CMD_PGWR) begin
            next_page = word_addr;
            next_state = SPFC_BUSY;
            next_op_cnt = 16'(OP_CYCLES);
            next_busy = word_addr < NO_READ_WHILE_WRITE_SECTION_START;
            next_halt = word_addr >= NO_READ_WHILE_WRITE_SECTION_START;
            do_erase = cmd == SPFC_CMD_PGER;
            do_write = cmd == SPFC_CMD_PGWR;
          end
          // Signature arming: store has no effect.
          if (cmd == SPFC_CMD_SIG && !reen) begin
            next_state = SPFC_IDLE;
          end
        end else if (load_in && (cmd == SPFC_CMD_SIG ||
                                 cmd == SPFC_CMD_LOCK) &&
                     win > (SPFC_STORE_WIN - SPFC_LOAD_WIN)) begin
          next_state = SPFC_IDLE;
        end else if (win == 3'h1) begin
          next_state = SPFC_IDLE;
        end
      end
      SPFC_BUSY: begin
        next_op_cnt = op_cnt - 16'h1;
        if (op_cnt == 16'h1) begin
          next_state = SPFC_IDLE;
          next_halt = 1'b0;
          if (cmd == SPFC_CMD_PGWR) begin
            next_filled = '0;
          end
        end
      end
      default: next_state = SPFC_IDLE;
    endcase
    if (halt) begin
      next_busy = next_busy & (next_page >= NO_READ_WHILE_WRITE_SECTION_START) ? busy : next_busy;
    end
  end

  // Command sequencer registers.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= SPFC_IDLE;
      ie <= 1'b0;
      busy <= 1'b0;
      cmd <= 5'h00;
      reen <= 1'b0;
      win <= 3'h0;
      op_cnt <= 16'h0;
      page <= 17'h0;
      ext <= 8'h00;
      lock <= 4'hf;
      filled <= '0;
      halt <= 1'b0;
    end else begin
      state <= next_state;
      ie <= next_ie;
      busy <= next_busy;
      cmd <= next_cmd;
      reen <= next_reen;
      win <= next_win;
      op_cnt <= next_op_cnt;
      page <= next_page;
      ext <= next_ext;
      lock <= next_lock;
      filled <= next_filled;
      halt <= next_halt;
    end
  end

  spfc_buf_mem u_buf (
    .clk_in(clk_sys_in),
    .we_in(buf_we),
    .waddr_in(widx),
    .wdata_in({r1_in, r0_in}),
    .raddr_in(widx),
    .rdata_out(buf_rdata)
  );

  // ----------------------------------------------------------------------
  // Outputs and register read
  // ----------------------------------------------------------------------
  logic [7:0] csr_view;
  logic [7:0] next_rdata;
  logic [7:0] next_ldata;
  logic next_lvalid;
  logic lock_read;

  // Status view: store enable shows arming and the busy operation.
  always_comb begin
    csr_view = 8'h00;
    csr_view[SPFC_BIT_IE] = ie;
    csr_view[SPFC_BIT_BUSY] = busy;
    if (state != SPFC_IDLE) begin
      csr_view[4:1] = reen ? 4'h8 : cmd[4:1];
      csr_view[SPFC_BIT_EN] = 1'b1;
      // Signature arming shows its own bit, not the re-enable bit.
      if (cmd == SPFC_CMD_SIG && !reen) begin
        csr_view[4:1] = 4'h0;
        csr_view[SPFC_BIT_SIG] = 1'b1;
      end
    end
  end

  // Load answers for lock, fuse and signature reads.
  assign lock_read = (state == SPFC_ARMED) && load_in && !ee_sync[1] &&
                     win > (SPFC_STORE_WIN - SPFC_LOAD_WIN);

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_in && reg_addr_in == SPFC_ADDR_CSR) begin
      next_rdata = csr_view;
    end else if (reg_rd_in && reg_addr_in == SPFC_ADDR_EXT) begin
      next_rdata = ext;
    end
    next_ldata = 8'h00;
    next_lvalid = 1'b0;
    if (lock_read && cmd == SPFC_CMD_LOCK && !reen) begin
      next_lvalid = 1'b1;
      // Z0 picks lock bits or the fuse byte.
      next_ldata = zptr[0] ? {2'h3, lock, 2'h3} : fuse_low_in;
    end else if (lock_read && cmd == SPFC_CMD_SIG && !reen) begin
      next_lvalid = 1'b1;
      next_ldata = signature_in;
    end
  end

  // All top outputs are registered.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 8'h00;
      load_data_out <= 8'h00;
      load_valid_out <= 1'b0;
      ready_irq_out <= 1'b0;
      rww_blocked_out <= 1'b0;
      cpu_halt_out <= 1'b0;
      reset_vector_out <= SPFC_APP_VECTOR;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_page_addr_out <= 17'h0;
      boot_lock_out <= 4'hf;
    end else begin
      reg_rdata_out <= next_rdata;
      load_data_out <= next_ldata;
      load_valid_out <= next_lvalid;
      ready_irq_out <= next_ie && global_ie_in &&
                       (next_state == SPFC_IDLE);
      rww_blocked_out <= next_busy;
      cpu_halt_out <= next_halt;
      // Fuse only from its pin; software has no path to it.
      reset_vector_out <= fuse_sync[1] ? SPFC_APP_VECTOR : BOOT_VECTOR;
      flash_erase_out <= do_erase;
      flash_write_out <= do_write;
      flash_page_addr_out <= next_page & ~17'(SPFC_BUF_WORDS - 1);
      boot_lock_out <= next_lock;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_armed;
    state == SPFC_ARMED && !store_in && !load_in;
  endsequence

  a_window_expiry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $rose(state == SPFC_ARMED) ##0 s_armed [*4]
    |=> state == SPFC_IDLE)
    else $error("store window longer than four cycles");

  a_busy_on_op: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (do_erase || do_write) && !next_halt |=> busy && state == SPFC_BUSY)
    else $error("busy not set on erase or write");

  a_irq_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    ready_irq_out |-> state == SPFC_IDLE)
    else $error("ready interrupt while store enable set");

  a_en_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    state == SPFC_BUSY |-> csr_view[SPFC_BIT_EN])
    else $error("store enable dropped during operation");

  a_illegal_cmd: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    state == SPFC_IDLE && wr_csr && !legal_cmd(wr_cmd)
    |=> state == SPFC_IDLE)
    else $error("illegal command armed");

  a_ee_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    state == SPFC_IDLE && ee_sync[1] |=> state == SPFC_IDLE)
    else $error("arming during eeprom write");

  a_vector_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    fuse_sync[1] |=> reset_vector_out == SPFC_APP_VECTOR)
    else $error("wrong application reset vector");

  a_fill_once: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    buf_we |-> !filled[widx] ##1 filled[$past(widx)])
    else $error("buffer location written twice");

endmodule
